// *** logic/cfg_preload.v ***
// EEPROM configuration preloader for a three-port switch.
// Assumes an EEPROM word reader on the same clock and an APB master.
// How it works
// - Word 06h bit 0 goes to 144h bit 0 on every port.
// - Word 06h bits 3:1 go to CCh bits 14:12, L0s exit latency.
// - Word 06h bits 6:4 go to CCh bits 17:15, L1 exit latency.
// - Word 06h bit 8 goes to 74h bit 5, no egress ordering.
// - Word 06h bit 9 goes to 74h bit 6, no tag ordering.
// - Word 06h bit 10 goes to 74h bit 0, store and forward.
// - Word 06h bits 12:11, 13, 14 go to 74h bits 2:1, 3, 4.
// - Word 06h bit 15 goes to 3Ch bit 8 on ports 1 and 2.
// - Word 0Ch bits 1:0 go to C4h bits 1:0, max payload.
// - Word 0Ch bits 3:2 go to CCh bits 11:10, ASPM support.
// - Word 0Ch bit 4 goes to C4h bit 15, role based errors.
// - Word 0Ch bit 5 goes to 70h bit 14, MSI disable.
// - Word 0Ch bit 6 goes to 74h bit 15, parity disable.
// - Word 0Ch bit 7 goes to 70h bit 13, PM disable.
// - Word 0Ch bit 8 goes to 8Ch bit 5, posted pass rule.
// - Word 0Ch bit 9 goes to CCh bit 21 on ports 1 and 2.
// - Word 0Ch bit 10 goes to 8Ch bit 6, ordering freeze.
// - Word 0Ch bit 11 goes to 8Ch bit 0, frame start latency.
// - Word 0Ch bit 12 goes to CCh bit 19, surprise down.
// - Word 0Ch bit 13 goes to 8Ch bit 1, data select R/W.
// - Word 0Ch bit 14 goes to E4h bit 12, LTR enable.
// - Word 0Ch bit 15 goes to 8Ch bit 3, 4KB check.
`timescale 1ns/100ps
`default_nettype none
`include "cfg_preload_defs.vh"

module cfg_preload #(
  parameter [15:0] SIGNATURE = 16'hA55A // Arbitrary value
) (
  input wire clock,
  input wire srst,
  // EEPROM word reader
  output reg ee_req,
  output reg [7:0] ee_addr,
  input wire ee_valid,
  input wire [15:0] ee_data,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg pready,
  output reg [31:0] prdata,
  output reg pslverr,
  // Loaded configuration, port p in bits [32p+31:32p]
  output reg [15:0] vendor_id,
  output reg [15:0] device_id,
  output reg [15:0] subsys_vendor_id,
  output reg [15:0] subsys_id,
  output wire [95:0] img_3c,
  output wire [95:0] img_70,
  output wire [95:0] img_74,
  output wire [95:0] img_8c,
  output wire [95:0] img_c4,
  output wire [95:0] img_cc,
  output wire [95:0] img_e4,
  output wire [95:0] img_144,
  output reg cfg_ready
);

  // ****************************************
  // Loader state machine
  // ****************************************
  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_REQ = 4'h2;
  localparam [3:0] S_WAIT = 4'h4;
  localparam [3:0] S_DONE = 4'h8;

  reg [3:0] state;
  reg [3:0] next_state;
  reg start;
  reg sig_ok;
  reg clear_img;
  reg load_misc;
  reg load_cap;
  reg [15:0] word;
  wire take;
  wire last;
  wire apb_done;
  wire reload;

  assign take = (state == S_WAIT) && ee_valid;
  assign last = (ee_addr == `EE_LAST_ADDR);

  // One word outstanding; the reader answers when it likes
  // Next state
  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (start) begin
          next_state = S_REQ;
        end
      end
      S_REQ: begin
        next_state = S_WAIT;
      end
      S_WAIT: begin
        if (ee_valid) begin
          if (ee_addr == `EE_SIG_ADDR && ee_data != SIGNATURE) begin
            next_state = S_DONE;
          end else if (last) begin
            next_state = S_DONE;
          end else begin
            next_state = S_REQ;
          end
        end
      end
      S_DONE: begin
        if (reload) begin
          next_state = S_REQ;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // State, request and address
  always @(posedge clock) begin
    if (srst) begin
      state <= S_IDLE;
      start <= 1'b1;
      ee_req <= 1'b0;
      ee_addr <= `EE_SIG_ADDR;
      sig_ok <= 1'b0;
      cfg_ready <= 1'b0;
      clear_img <= 1'b0;
    end else begin
      state <= next_state;
      start <= 1'b0;
      ee_req <= (next_state == S_REQ);
      clear_img <= 1'b0;
      // Each run clears first so no stale field survives a reload
      if ((state == S_IDLE && start) || (state == S_DONE && reload)) begin
        ee_addr <= `EE_SIG_ADDR;
        sig_ok <= 1'b0;
        cfg_ready <= 1'b0;
        clear_img <= 1'b1;
      end else if (take) begin
        if (ee_addr == `EE_SIG_ADDR) begin
          sig_ok <= (ee_data == SIGNATURE);
        end
        if (!last) begin
          ee_addr <= ee_addr + `EE_ADDR_STEP;
        end
      end
      // A bad signature also ends in done, so no access hangs
      // accesses released when done
      cfg_ready <= (next_state == S_DONE);
    end
  end

  // Word strobes for the per-port images
  // The word is caught every cycle; the strobe a cycle later reads it
  always @(posedge clock) begin
    if (srst) begin
      load_misc <= 1'b0;
      load_cap <= 1'b0;
      word <= 16'h0000;
    end else begin
      load_misc <= take && (ee_addr == `EE_MISC_ADDR);
      load_cap <= take && (ee_addr == `EE_CAP_ADDR);
      word <= ee_data;
    end
  end

  // ****************************************
  // Identification words
  // ****************************************
  // identifier loads
  always @(posedge clock) begin
    if (srst || clear_img) begin
      vendor_id <= `RST_ID;
      device_id <= `RST_ID;
      subsys_vendor_id <= `RST_ID;
      subsys_id <= `RST_ID;
    end else if (take) begin
      if (ee_addr == `EE_VID_ADDR) begin
        vendor_id <= ee_data;
      end
      if (ee_addr == `EE_DID_ADDR) begin
        device_id <= ee_data;
      end
      if (ee_addr == `EE_SVID_ADDR) begin
        subsys_vendor_id <= ee_data;
      end
      if (ee_addr == `EE_SSID_ADDR) begin
        subsys_id <= ee_data;
      end
    end
  end

  // ****************************************
  // Per-port configuration images
  // ****************************************
  // Unloaded bits keep their default of zero
  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1) begin : port
      reg [31:0] r3c, r70, r74, r8c, rc4, rcc, re4, r144;
      assign img_3c[32*p+31:32*p] = r3c;
      assign img_70[32*p+31:32*p] = r70;
      assign img_74[32*p+31:32*p] = r74;
      assign img_8c[32*p+31:32*p] = r8c;
      assign img_c4[32*p+31:32*p] = rc4;
      assign img_cc[32*p+31:32*p] = rcc;
      assign img_e4[32*p+31:32*p] = re4;
      assign img_144[32*p+31:32*p] = r144;

      always @(posedge clock) begin
        if (srst || clear_img) begin
          r3c <= `RST_IMG;
          r70 <= `RST_IMG;
          r74 <= `RST_IMG;
          r8c <= `RST_IMG;
          rc4 <= `RST_IMG;
          rcc <= `RST_IMG;
          re4 <= `RST_IMG;
          r144 <= `RST_IMG;
        end else begin
          if (load_misc) begin
            r144[`D144_VC] <= word[`W6_VC];
            rcc[`DCC_L0S_LO+2:`DCC_L0S_LO] <= word[`W6_L0S_LO+2:`W6_L0S_LO];
            rcc[`DCC_L1_LO+2:`DCC_L1_LO] <= word[`W6_L1_LO+2:`W6_L1_LO];
            r74[`D74_NO_EGR_ORD] <= word[`W6_NO_EGR_ORD];
            r74[`D74_NO_TAG_ORD] <= word[`W6_NO_TAG_ORD];
            r74[`D74_SNF] <= word[`W6_SNF];
            r74[`D74_CT_LO+1:`D74_CT_LO] <= word[`W6_CT_LO+1:`W6_CT_LO];
            r74[`D74_ARB] <= word[`W6_ARB];
            r74[`D74_CRD] <= word[`W6_CRD];
            if (p != 0) begin
              r3c[`D3C_INTA] <= word[`W6_INTA];
            end
          end
          if (load_cap) begin
            rc4[`DC4_MPS_LO+1:`DC4_MPS_LO] <= word[`WC_MPS_LO+1:`WC_MPS_LO];
            rcc[`DCC_ASPM_LO+1:`DCC_ASPM_LO] <= word[`WC_ASPM_LO+1:`WC_ASPM_LO];
            rc4[`DC4_RBER] <= word[`WC_RBER];
            r70[`D70_MSI_DIS] <= word[`WC_MSI_DIS];
            r74[`D74_PAR_DIS] <= word[`WC_PAR_DIS];
            r70[`D70_PM_DIS] <= word[`WC_PM_DIS];
            r8c[`D8C_PPASS] <= word[`WC_PPASS];
            if (p != 0) begin
              rcc[`DCC_LBN] <= word[`WC_LBN];
            end
            r8c[`D8C_FREEZE] <= word[`WC_FREEZE];
            r8c[`D8C_SOF] <= word[`WC_SOF];
            rcc[`DCC_SDN] <= word[`WC_SDN];
            r8c[`D8C_DSEL] <= word[`WC_DSEL];
            re4[`DE4_LTR] <= word[`WC_LTR];
            r8c[`D8C_4KB] <= word[`WC_4KB];
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // APB slave
  // ****************************************
  reg [1:0] port_sel;
  reg reload_req;
  reg [31:0] rd_word;
  reg rd_err;
  reg [31:0] status_word;
  wire [6:0] slice_lsb;
  wire access;
  wire is_status;

  // Port select of 3 is refused, so the slice always stays in range
  assign slice_lsb = {port_sel, 5'h00};
  assign access = psel && penable && !pready;
  assign is_status = (paddr == `A_STATUS);
  assign apb_done = psel && penable && pready;
  assign reload = reload_req;

  // Status word for software
  always @* begin
    status_word = 32'h00000000;
    status_word[`ST_DONE] = cfg_ready;
    status_word[`ST_SIG_OK] = sig_ok;
    status_word[`ST_BUSY] = (state != S_DONE);
  end

  // Read mux and address decode
  always @* begin
    rd_word = 32'h00000000;
    rd_err = 1'b0;
    case (paddr)
      `A_CTRL: rd_word = 32'h00000000;
      `A_STATUS: rd_word = status_word;
      `A_IDS: rd_word = {device_id, vendor_id};
      `A_SUBIDS: rd_word = {subsys_id, subsys_vendor_id};
      `A_PORTSEL: rd_word = {30'h00000000, port_sel};
      `A_IMG_BASE: rd_word = img_3c[slice_lsb +: 32];
      `A_IMG_70: rd_word = img_70[slice_lsb +: 32];
      `A_IMG_74: rd_word = img_74[slice_lsb +: 32];
      `A_IMG_8C: rd_word = img_8c[slice_lsb +: 32];
      `A_IMG_C4: rd_word = img_c4[slice_lsb +: 32];
      `A_IMG_CC: rd_word = img_cc[slice_lsb +: 32];
      `A_IMG_E4: rd_word = img_e4[slice_lsb +: 32];
      `A_IMG_LAST: rd_word = img_144[slice_lsb +: 32];
      default: rd_err = 1'b1;
    endcase
    if (paddr == `A_PORTSEL && pwrite && pwdata[1:0] == 2'b11) begin
      rd_err = 1'b1;
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      port_sel <= 2'b00;
      reload_req <= 1'b0;
    end else begin
      pready <= access && (cfg_ready || is_status);
      reload_req <= 1'b0;
      if (access && (cfg_ready || is_status)) begin
        prdata <= pwrite ? 32'h00000000 : rd_word;
        pslverr <= rd_err;
      end
      // A refused write leaves port select and reload alone
      if (apb_done && pwrite && !pslverr) begin
        if (paddr == `A_PORTSEL) begin
          port_sel <= pwdata[1:0];
        end
        if (paddr == `A_CTRL && pwdata[`CTRL_RELOAD]) begin
          reload_req <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// *** logic/cfg_preload_defs.vh ***
// Constants for the EEPROM configuration preloader.
// Assumes one 16-bit word interface to a serial EEPROM reader.
`ifndef CFG_PRELOAD_DEFS_VH
`define CFG_PRELOAD_DEFS_VH

// ****************************************
// EEPROM byte addresses of loaded words
// ****************************************
`define EE_SIG_ADDR 8'h00
`define EE_VID_ADDR 8'h02
`define EE_DID_ADDR 8'h04
`define EE_MISC_ADDR 8'h06
`define EE_SVID_ADDR 8'h08
`define EE_SSID_ADDR 8'h0A
`define EE_CAP_ADDR 8'h0C
`define EE_LAST_ADDR 8'h0C
`define EE_ADDR_STEP 8'h02

// ****************************************
// Word 06h source fields
// ****************************************
`define W6_VC 0
`define W6_L0S_LO 1
`define W6_L1_LO 4
`define W6_NO_EGR_ORD 8
`define W6_NO_TAG_ORD 9
`define W6_SNF 10
`define W6_CT_LO 11
`define W6_ARB 13
`define W6_CRD 14
`define W6_INTA 15

// ****************************************
// Word 0Ch source fields
// ****************************************
`define WC_MPS_LO 0
`define WC_ASPM_LO 2
`define WC_RBER 4
`define WC_MSI_DIS 5
`define WC_PAR_DIS 6
`define WC_PM_DIS 7
`define WC_PPASS 8
`define WC_LBN 9
`define WC_FREEZE 10
`define WC_SOF 11
`define WC_SDN 12
`define WC_DSEL 13
`define WC_LTR 14
`define WC_4KB 15

// ****************************************
// Destination bit positions
// ****************************************
`define D144_VC 0
`define DCC_L0S_LO 12
`define DCC_L1_LO 15
`define DCC_ASPM_LO 10
`define DCC_LBN 21
`define DCC_SDN 19
`define D74_SNF 0
`define D74_CT_LO 1
`define D74_ARB 3
`define D74_CRD 4
`define D74_NO_EGR_ORD 5
`define D74_NO_TAG_ORD 6
`define D74_PAR_DIS 15
`define D3C_INTA 8
`define DC4_MPS_LO 0
`define DC4_RBER 15
`define D70_PM_DIS 13
`define D70_MSI_DIS 14
`define D8C_SOF 0
`define D8C_DSEL 1
`define D8C_4KB 3
`define D8C_PPASS 5
`define D8C_FREEZE 6
`define DE4_LTR 12

// ****************************************
// Hardware defaults of the images
// ****************************************
`define RST_IMG 32'h00000000
`define RST_ID 16'h0000

// ****************************************
// APB register byte offsets
// ****************************************
`define A_CTRL 8'h00
`define A_STATUS 8'h04
`define A_IDS 8'h08
`define A_SUBIDS 8'h0C
`define A_PORTSEL 8'h10
`define A_IMG_BASE 8'h20
`define A_IMG_70 8'h24
`define A_IMG_74 8'h28
`define A_IMG_8C 8'h2C
`define A_IMG_C4 8'h30
`define A_IMG_CC 8'h34
`define A_IMG_E4 8'h38
`define A_IMG_LAST 8'h3C
`define CTRL_RELOAD 0
`define ST_DONE 0
`define ST_SIG_OK 1
`define ST_BUSY 2

`endif

// *** verif/cfg_preload_monitor.sv ***
// Port checker for the configuration preloader.
// Assumes bind into cfg_preload, single clock, srst synchronous.
`timescale 1ns/100ps
`default_nettype none
module cfg_preload_monitor #(
  parameter [15:0] SIGNATURE = 16'hA55A // Arbitrary value
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic ee_req,
  input wire logic [7:0] ee_addr,
  input wire logic ee_valid,
  input wire logic [15:0] ee_data,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic [15:0] vendor_id,
  input wire logic [95:0] img_3c,
  input wire logic [95:0] img_70,
  input wire logic [95:0] img_74,
  input wire logic [95:0] img_8c,
  input wire logic [95:0] img_c4,
  input wire logic [95:0] img_cc,
  input wire logic [95:0] img_e4,
  input wire logic [95:0] img_144,
  input wire logic cfg_ready
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  // ****
  // Load steps
  // ****
  sequence s_bad_sig;
    ee_valid && ee_addr == 8'h00 && ee_data != SIGNATURE;
  endsequence
  property p_vid;
    logic [15:0] v;
    (ee_valid && ee_addr == 8'h02, v = ee_data) |-> ##3 vendor_id == v;
  endproperty
  property p_misc;
    logic [15:0] v;
    (ee_valid && ee_addr == 8'h06, v = ee_data) |-> ##3 img_144[0] == v[0]
      && img_cc[81:76] == v[6:1] && img_74[6:0] == {v[9:8], v[14:10]};
  endproperty
  property p_inta;
    logic [15:0] v;
    (ee_valid && ee_addr == 8'h06, v = ee_data) |-> ##3 !img_3c[8]
      && img_3c[40] == v[15] && img_3c[72] == v[15];
  endproperty
  property p_cap;
    logic [15:0] v;
    (ee_valid && ee_addr == 8'h0C, v = ee_data) |-> ##3 cfg_ready
      && img_c4[15:0] == {v[4], 13'h0, v[1:0]} && img_70[14:13] == {v[5], v[7]}
      && img_cc[43:42] == v[3:2] && img_74[47] == v[6] && img_8c[5] == v[8];
  endproperty
  property p_cap_link;
    logic [15:0] v;
    (ee_valid && ee_addr == 8'h0C, v = ee_data) |-> ##3 img_cc[53] == v[9] && !img_cc[21]
      && img_8c[6:0] == {v[10], v[8], 1'b0, v[15], 1'b0, v[13], v[11]}
      && img_cc[19] == v[12] && img_e4[76] == v[14];
  endproperty
  property p_copies;
    cfg_ready |-> img_74[31:0] == img_74[95:64] && img_8c[31:0] == img_8c[63:32]
      && img_70[63:32] == img_70[95:64] && img_c4[31:0] == img_c4[95:64]
      && img_e4[31:0] == img_e4[63:32] && img_144[31:0] == img_144[95:64];
  endproperty
  a_bad_sig_stop: assert property (s_bad_sig |=> (!ee_req) [*4]) else $error("load went on");
  a_bad_sig_done: assert property (s_bad_sig |-> ##[1:3] (cfg_ready && img_cc == 96'h0
    && vendor_id == 16'h0)) else $error("bad signature not finished clean");
  a_vendor_load: assert property (p_vid) else $error("vendor id not loaded");
  a_next_word: assert property (ee_valid && ee_addr != 8'h0C
    && (ee_addr != 8'h00 || ee_data == SIGNATURE) |-> ##[1:2] ee_req)
    else $error("next word not requested");
  a_misc_fields: assert property (p_misc)
    else $error("word 06 fields wrong");
  a_inta_ports: assert property (p_inta) else $error("interrupt pin bits wrong");
  a_cap_fields: assert property (p_cap)
    else $error("word 0C fields wrong");
  a_cap_link: assert property (p_cap_link)
    else $error("word 0C link fields wrong");
  a_port_copies: assert property (p_copies) else $error("port images differ");
  a_apb_stall: assert property (psel && penable && !cfg_ready && paddr != 8'h04
    |=> !pready) else $error("access answered during preload");
  a_pready_pulse: assert property (pready |=> !pready) else $error("pready longer than a cycle");
endmodule
bind cfg_preload cfg_preload_monitor #(.SIGNATURE(SIGNATURE)) u_cfg_preload_monitor (
  .clock(clock), .srst(srst), .ee_req(ee_req), .ee_addr(ee_addr), .ee_valid(ee_valid),
  .ee_data(ee_data), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .vendor_id(vendor_id), .img_3c(img_3c), .img_70(img_70), .img_74(img_74),
  .img_8c(img_8c), .img_c4(img_c4), .img_cc(img_cc), .img_e4(img_e4),
  .img_144(img_144), .cfg_ready(cfg_ready));
`default_nettype wire

// *** verif/ee_model.sv ***
// Behavioural EEPROM word reader holding eight words.
// Assumes the loader's clock; answer delay set by the bench.
`timescale 1ns/100ps
`default_nettype none
module ee_model (
  input wire logic clock,
  input wire logic srst,
  input wire logic ee_req,
  input wire logic [7:0] ee_addr,
  input wire logic [7:0] delay,
  output logic ee_valid,
  output logic [15:0] ee_data
);
  logic [15:0] mem [0:7];
  logic [7:0] cnt;
  logic busy;
  logic [2:0] idx;
  // ****
  // Reader
  // ****
  initial begin
    ee_valid = 1'b0;
    ee_data = 16'h0000;
  end
  // One word per request; data toggles when not valid
  always @(posedge clock) begin
    ee_valid <= 1'b0;
    ee_data <= ~ee_data;
    if (srst) begin
      busy <= 1'b0;
      cnt <= 8'h00;
    end else if (ee_req) begin
      busy <= 1'b1;
      cnt <= delay;
      idx <= ee_addr[3:1];
    end else if (busy && cnt == 8'h00) begin
      busy <= 1'b0;
      ee_valid <= 1'b1;
      ee_data <= mem[idx];
    end else if (busy) begin
      cnt <= cnt - 8'h01;
    end
  end
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the configuration preloader.
// Assumes the EEPROM model and an APB master task on one clock.
`timescale 1ns/100ps
`default_nettype none
`include "cfg_preload_defs.vh"
module tb;
  localparam [15:0] SIG = 16'hA55A; // Arbitrary value
  localparam [15:0] A6 = 16'hA5C3;
  localparam [15:0] AC = 16'h5A69;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [7:0] delay = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  wire ee_req, ee_valid, pready, pslverr, cfg_ready;
  wire [7:0] ee_addr;
  wire [15:0] ee_data, vendor_id, device_id, subsys_vendor_id, subsys_id;
  wire [31:0] prdata;
  wire [95:0] imgs [0:7];
  int num_errors = 0;
  int checks = 0;
  logic [31:0] rd;
  logic er;
  always #4 clock = ~clock;
  cfg_preload #(.SIGNATURE(SIG)) u_cfg_preload (.clock(clock), .srst(srst),
    .ee_req(ee_req), .ee_addr(ee_addr), .ee_valid(ee_valid), .ee_data(ee_data),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .vendor_id(vendor_id),
    .device_id(device_id), .subsys_vendor_id(subsys_vendor_id), .subsys_id(subsys_id),
    .img_3c(imgs[0]), .img_70(imgs[1]), .img_74(imgs[2]), .img_8c(imgs[3]),
    .img_c4(imgs[4]), .img_cc(imgs[5]), .img_e4(imgs[6]), .img_144(imgs[7]),
    .cfg_ready(cfg_ready));
  ee_model u_ee_model (.clock(clock), .srst(srst), .ee_req(ee_req), .ee_addr(ee_addr),
    .delay(delay), .ee_valid(ee_valid), .ee_data(ee_data));
  // ****
  // Helpers
  // ****
  task automatic check(input logic [31:0] act, input logic [31:0] exp, input string what);
    checks++;
    if (act !== exp) begin
      num_errors++;
      $display("ERROR %0t %s got %h want %h", $time, what, act, exp);
    end
  endtask
  // APB transfer held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (n = 0; n < 4000; n++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    check({31'h0, pready}, 32'h1, "apb answer");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic set_mem(input logic [15:0] sig, w6, wc, base);
    u_ee_model.mem[0] = sig;
    u_ee_model.mem[1] = base;
    u_ee_model.mem[2] = base + 16'h1;
    u_ee_model.mem[3] = w6;
    u_ee_model.mem[4] = base + 16'h2;
    u_ee_model.mem[5] = base + 16'h3;
    u_ee_model.mem[6] = wc;
    u_ee_model.mem[7] = 16'hFFFF;
  endtask
  // Expected image k of port p
  function automatic logic [31:0] exp_img(input logic [15:0] w6, wc, input int p, k,
                                          input logic ok);
    logic [31:0] r;
    r = 32'h0;
    case (k)
      0: r[8] = (p != 0) & w6[15];
      1: r[14:13] = {wc[5], wc[7]};
      2: r[15:0] = {wc[6], 8'h0, w6[9:8], w6[14:10]};
      3: r[6:0] = {wc[10], wc[8], 1'b0, wc[15], 1'b0, wc[13], wc[11]};
      4: r[15:0] = {wc[4], 13'h0, wc[1:0]};
      5: r[21:10] = {(p != 0) & wc[9], 1'b0, wc[12], 1'b0, w6[6:1], wc[3:2]};
      6: r[12] = wc[14];
      default: r[0] = w6[0];
    endcase
    return ok ? r : 32'h0;
  endfunction
  task automatic check_all(input logic [15:0] w6, wc, base, input logic ok);
    int p, k;
    apb(1'b0, `A_SUBIDS, 32'h0);
    check(rd, ok ? {base + 16'h3, base + 16'h2} : 32'h0, "subsystem ids");
    check({subsys_id, subsys_vendor_id}, ok ? {base + 16'h3, base + 16'h2} : 32'h0,
          "subsystem outputs");
    check({16'h0, device_id}, ok ? {16'h0, base + 16'h1} : 32'h0, "device id");
    for (p = 0; p < 3; p++) begin
      apb(1'b1, `A_PORTSEL, 32'(p));
      for (k = 0; k < 8; k++) begin
        check(imgs[k][32*p +: 32], exp_img(w6, wc, p, k, ok),
              "image");
        apb(1'b0, `A_IMG_BASE + 8'(4 * k), 32'h0);
        check(rd, exp_img(w6, wc, p, k, ok), "image read");
      end
    end
    apb(1'b0, `A_STATUS, 32'h0);
    check(rd, {29'h0, 1'b0, ok, 1'b1}, "status");
  endtask
  // ****
  // Tests
  // ****
  task automatic test_power_up;
    int n;
    for (n = 0; n < 3000 && cfg_ready !== 1'b1; n++) @(posedge clock);
    check({31'h0, cfg_ready}, 32'h1, "preload done");
    check({16'h0, vendor_id}, 32'h1234, "vendor id");
    check_all(A6, AC, 16'h1234, 1'b1);
    $display("test power_up done");
  endtask
  task automatic test_reload_slow;
    set_mem(SIG, ~A6, ~AC, 16'h4321);
    delay <= 8'h05;
    apb(1'b1, `A_CTRL, 32'h1);
    apb(1'b0, `A_STATUS, 32'h0);
    check(rd, 32'h00000004, "busy while loading");
    apb(1'b0, `A_IDS, 32'h0);
    check({31'h0, cfg_ready}, 32'h1, "access waited");
    check(rd, 32'h43224321, "ids");
    check_all(~A6, ~AC, 16'h4321, 1'b1);
    $display("test reload_slow done");
  endtask
  task automatic test_bad_sig;
    set_mem(~SIG, A6, AC, 16'h1111);
    delay <= 8'h00;
    apb(1'b1, `A_CTRL, 32'h1);
    apb(1'b0, `A_IDS, 32'h0);
    check(rd, 32'h0, "ids stay default");
    check_all(A6, AC, 16'h1111, 1'b0);
    $display("test bad_sig done");
  endtask
  task automatic test_errors;
    apb(1'b0, 8'h40, 32'h0);
    check({31'h0, er}, 32'h1, "unmapped error");
    apb(1'b1, `A_PORTSEL, 32'h3);
    check({31'h0, er}, 32'h1, "port select error");
    apb(1'b0, `A_CTRL, 32'h0);
    check(rd, 32'h0, "control reads zero");
    $display("test errors done");
  endtask
  task final_report;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    set_mem(SIG, A6, AC, 16'h1234);
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    test_power_up;
    test_reload_slow;
    test_bad_sig;
    test_errors;
    final_report;
  end
  // Watchdog
  initial begin
    repeat (40000) @(posedge clock);
    num_errors++;
    final_report;
  end
endmodule
`default_nettype wire
